/* File: board_interrupt_routing.sv */
/*
   Interrupt routing for a communicating single-board processor: a master and a
   cascaded slave priority_interrupt_unit, flag-byte handshake both ways, latches
   and jumper matrices. Assumes APB master on clk_sys; pins arrive asynchronously.
*/
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns

// Summary of operation
// RL1: Master unit takes slave unit's request on its cascade input.
// RL2: Two master inputs come from the serial controllers for vectoring.
// RL3: Twenty-two priority levels reach the processor in total; the code vectors 12 (seven master levels, five slave levels) plus nmi.
// RL4: Non-maskable line goes straight to processor, highest priority.
// RL5: Slave unit serves three timers and two DMA channels.
// RL6: Master unit has eight levels, one being the cascade.
// RL7: Eight system bus request levels are accepted.
// RL8: No bus-vectored cycles; bus requests are plain levels.
// RL9: Four serial devices give eight causes each, 32 total.
// RL10: Three master-chip timer outputs are interrupt sources.
// RL11: System bus I/O write to flag byte raises one request.
// RL12: Processor I/O write raises bus interrupt on selectable line 0-7.
// RL13: Two expansion connectors give two request lines each.
// RL14: Timeout interrupt on long bus wait or missing acknowledge.
// RL15: Latch turns dma_end_of_process pulse into level request.
// RL16: OR matrix merges up to four jumper-selected sources.
// RL17: Latch captures ring indicator from serial channels 4 to 7.
// RL18: NOR matrix merges and inverts up to two selected sources.
// RL19: Flag-byte handshake works in both directions.
// RL20: Pulse and ring latches hold until cleared or reset.
// RL21: Flag interrupts stay asserted until receiver acknowledges.
module board_interrupt_routing
   import irq_routing_pkg::*;
#(
   parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire apb_req_type apb_req,
   output apb_rsp_type apb_rsp,
   input wire logic [SERIAL_DEVICES*CAUSES_PER_DEVICE-1:0] serial_cause,
   input wire logic [2:0] slave_timer,
   input wire logic [1:0] slave_dma,
   input wire logic [2:0] master_timer,
   input wire logic [BUS_LEVELS-1:0] bus_int_in,
   input wire logic [3:0] expansion_int,
   input wire logic power_fail,
   input wire logic dma_end_of_process,
   input wire logic [3:0] ring_indicator,
   input wire logic bus_flag_write,
   input wire logic bus_request,
   input wire logic bus_granted,
   input wire logic bus_cycle,
   input wire logic bus_ack,
   output logic nmi,
   output logic cpu_int,
   output logic [4:0] cpu_vector,
   output logic [BUS_LEVELS-1:0] bus_int_out,
   output glue_state_type glue_state
);

   localparam int NSYNC = 11;

   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] sync3;
   logic [NSYNC-1:0] clean;
   logic [NSYNC-1:0] clean_d;
   logic [NSYNC-1:0] raw_pins;

   logic [2:0] bus_line;
   logic [3:0] or_sel;
   logic [1:0] nor_sel;
   logic [MASTER_LEVELS-1:0] master_mask;
   logic [MASTER_LEVELS-1:0] slave_mask;
   logic pulse_latch;
   logic ring_latch;
   logic flag_in;
   logic flag_out;
   logic timeout_flag;
   logic [15:0] wait_count;
   logic [SERIAL_DEVICES-1:0] serial_any;
   logic or_out;
   logic nor_out;
   logic [SLAVE_LEVELS-1:0] slave_req;
   logic slave_cascade;
   logic [MASTER_LEVELS-1:0] master_req;
   logic [MASTER_LEVELS-1:0] master_pend;
   logic [2:0] next_master_level;
   logic [2:0] next_slave_level;
   logic next_cpu_int;
   logic wr_en;
   logic rd_en;
   logic known;

   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = i[2:0];
         end
      end
      return r;
   endfunction

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // Handshake, latch and power-fail pins pass three flops; change counted once stages two and three agree
   assign raw_pins = {ring_indicator, dma_end_of_process, bus_flag_write,
                      bus_request, bus_granted, bus_cycle, bus_ack,
                      power_fail};

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         clean <= '0;
         clean_d <= '0;
      end
      else
      begin
         sync1 <= raw_pins;
         sync2 <= sync1;
         sync3 <= sync2;
         clean <= ((sync2 ~^ sync3) & sync2) | (~(sync2 ~^ sync3) & clean);
         clean_d <= clean;
      end
   end

   logic ri_any;
   logic eop_rise;
   logic flag_wr_rise;
   logic s_bus_req;
   logic s_bus_grant;
   logic s_bus_cycle;
   logic s_bus_ack;
   logic s_power_fail;

   assign ri_any = |(clean[10:7] & ~clean_d[10:7]);
   assign eop_rise = clean[6] & ~clean_d[6];
   assign flag_wr_rise = clean[5] & ~clean_d[5];
   assign s_bus_req = clean[4];
   assign s_bus_grant = clean[3];
   assign s_bus_cycle = clean[2];
   assign s_bus_ack = clean[1];
   assign s_power_fail = clean[0];

   // All bus levels get their own synchroniser, one filter per bit
   logic [BUS_LEVELS-1:0] bus_s1;
   logic [BUS_LEVELS-1:0] bus_s2;
   logic [BUS_LEVELS-1:0] bus_s3;
   logic [BUS_LEVELS-1:0] bus_level;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bus_s1 <= '0;
         bus_s2 <= '0;
         bus_s3 <= '0;
         bus_level <= '0;
      end
      else
      begin
         bus_s1 <= bus_int_in;
         bus_s2 <= bus_s1;
         bus_s3 <= bus_s2;
         bus_level <= ((bus_s2 ~^ bus_s3) & bus_s2) | (~(bus_s2 ~^ bus_s3) & bus_level); // RL8
      end
   end

   // APB slave: zero wait states
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

   always_comb
   begin
      known = 1'b0;
      for (int k = 0; k <= 10; k++)
      begin
         if (is_reg(apb_req.paddr, 8'(k * 4)))
         begin
            known = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bus_line <= RST_BUS_LINE;
         or_sel <= RST_OR_SEL;
         nor_sel <= RST_NOR_SEL;
         master_mask <= RST_MASK;
         slave_mask <= RST_MASK;
      end
      else if (wr_en)
      begin
         if (is_reg(apb_req.paddr, OFS_CTRL))
         begin
            bus_line <= apb_req.pwdata[CTRL_BUS_LINE_LSB +: CTRL_BUS_LINE_W]; // RL12
         end
         if (is_reg(apb_req.paddr, OFS_OR_SEL))
         begin
            or_sel <= apb_req.pwdata[3:0]; // RL16
         end
         if (is_reg(apb_req.paddr, OFS_NOR_SEL))
         begin
            nor_sel <= apb_req.pwdata[1:0]; // RL18
         end
         if (is_reg(apb_req.paddr, OFS_MASTER_MASK))
         begin
            master_mask <= apb_req.pwdata[7:0];
         end
         if (is_reg(apb_req.paddr, OFS_SLAVE_MASK))
         begin
            slave_mask <= apb_req.pwdata[7:0];
         end
      end
   end

   logic clr_wr;
   logic [31:0] clr_bits;
   assign clr_wr = wr_en & is_reg(apb_req.paddr, OFS_LATCH_CLR);
   assign clr_bits = clr_wr ? apb_req.pwdata : 32'h0000_0000;

   // Event set wins over a same-cycle clear
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pulse_latch <= 1'b0; // RL20
         ring_latch <= 1'b0; // RL20
      end
      else
      begin
         pulse_latch <= eop_rise | (pulse_latch & ~clr_bits[ST_PULSE_LATCH]); // RL15 RL20
         ring_latch <= ri_any | (ring_latch & ~clr_bits[ST_RING_LATCH]); // RL17 RL20
      end
   end

   // Flag byte handshake
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         flag_in <= 1'b0;
         flag_out <= 1'b0;
      end
      else
      begin
         flag_in <= flag_wr_rise | (flag_in & ~clr_bits[ST_FLAG_IN]); // RL11 RL19 RL21
         flag_out <= (wr_en & is_reg(apb_req.paddr, OFS_FLAG_SET))
                     | (flag_out & ~(wr_en & is_reg(apb_req.paddr, OFS_FLAG_ACK))); // RL12 RL19 RL21
      end
   end

   // Drives the selected bus line while the flag stands
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bus_int_out <= '0;
      end
      else
      begin
         bus_int_out <= flag_out ? (8'h01 << bus_line) : 8'h00; // RL12
      end
   end

   // Fail-safe timer: waiting for grant or for acknowledge
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wait_count <= '0;
         timeout_flag <= 1'b0;
      end
      else
      begin
         if ((s_bus_req & ~s_bus_grant) | (s_bus_cycle & ~s_bus_ack))
         begin
            if (wait_count != 16'(TIMEOUT_LIMIT))
            begin
               wait_count <= wait_count + 16'h0001;
            end
         end
         else
         begin
            wait_count <= '0;
         end
         timeout_flag <= (wait_count == 16'(TIMEOUT_LIMIT - 1))
                         | (timeout_flag & ~clr_bits[ST_TIMEOUT]); // RL14
      end
   end

   // Each serial device concentrates its eight causes
   genvar g;
   generate
      for (g = 0; g < SERIAL_DEVICES; g++)
      begin : serial_or
         assign serial_any[g] = |serial_cause[g*CAUSES_PER_DEVICE +: CAUSES_PER_DEVICE]; // RL9
      end
   endgenerate

   assign or_out = |({expansion_int[3], timeout_flag, ring_latch, pulse_latch} & or_sel); // RL16
   assign nor_out = ~|({expansion_int[2], flag_in} & nor_sel) & (|nor_sel); // RL18

   assign slave_req = {slave_dma, slave_timer}; // RL5
   assign slave_cascade = |(slave_req & slave_mask[SLAVE_LEVELS-1:0]); // RL1

   assign master_req[0] = serial_any[0] | serial_any[1]; // RL2
   assign master_req[1] = serial_any[2] | serial_any[3]; // RL2
   assign master_req[4:2] = master_timer; // RL10
   assign master_req[5] = flag_in | or_out | nor_out | |bus_level; // RL7 RL11
   assign master_req[6] = |expansion_int[1:0]; // RL13
   assign master_req[CASCADE_INPUT] = slave_cascade; // RL1 RL6
   assign master_pend = master_req & master_mask;

   always_comb
   begin
      next_master_level = first_set(master_pend);
      next_slave_level = first_set({3'h0, slave_req & slave_mask[SLAVE_LEVELS-1:0]});
      next_cpu_int = |master_pend;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         nmi <= 1'b0;
         cpu_int <= 1'b0;
         cpu_vector <= '0;
      end
      else
      begin
         nmi <= s_power_fail; // RL4
         cpu_int <= next_cpu_int; // RL3
         cpu_vector <= (next_master_level == 3'(CASCADE_INPUT))
                       ? {2'b10, next_slave_level} : {2'b00, next_master_level}; // RL1 RL3
      end
   end

   assign glue_state = '{pulse_latch: pulse_latch, ring_latch: ring_latch, flag_in: flag_in,
                         flag_out: flag_out, timeout: timeout_flag};

   // Read mux; zero wait states, unmapped gives pslverr
   always_comb
   begin
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~known;
      apb_rsp.prdata = 32'h0000_0000;
      if (rd_en)
      begin
         case (apb_req.paddr)
            OFS_CTRL: apb_rsp.prdata = {29'h0, bus_line};
            OFS_STATUS: apb_rsp.prdata = {27'h0, timeout_flag, flag_out, flag_in, ring_latch, pulse_latch};
            OFS_OR_SEL: apb_rsp.prdata = {28'h0, or_sel};
            OFS_NOR_SEL: apb_rsp.prdata = {30'h0, nor_sel};
            OFS_MASTER_MASK: apb_rsp.prdata = {24'h0, master_mask};
            OFS_SLAVE_MASK: apb_rsp.prdata = {24'h0, slave_mask};
            OFS_PENDING: apb_rsp.prdata = {16'h0, bus_level, master_pend};
            OFS_TIMEOUT: apb_rsp.prdata = {16'h0, wait_count};
            default: apb_rsp.prdata = 32'h0000_0000;
         endcase
      end
   end

endmodule

/* File: bus_host_model.sv */
/*
   System bus side: arbiter grant, transfer acknowledge, flag-byte write.
   Assumes bench commands on clk_sys; stall withholds grant and acknowledge.
*/
`timescale 1ns/1ns
module bus_host_model
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic flag_go,
   input wire logic bus_request,
   input wire logic bus_cycle,
   output logic bus_granted,
   output logic bus_ack,
   output logic bus_flag_write
);
   logic [1:0] strobe_cnt;
   always_ff @(posedge clk_sys)
   begin
      bus_granted <= rst_n && bus_request && !stall;
      bus_ack <= rst_n && bus_cycle && !stall;
   end
   // Three cycles wide so the synchroniser cannot miss it
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         strobe_cnt <= 2'h0;
      else if (flag_go)
         strobe_cnt <= 2'h3;
      else if (strobe_cnt != 2'h0)
         strobe_cnt <= strobe_cnt - 2'h1;
   end
   assign bus_flag_write = strobe_cnt != 2'h0;
endmodule

/* File: irq_routing_chk.sv */
/*
   Port assertions for the interrupt routing block.
   Assumes binding to the top module, one clock, sync active-low reset.
*/
`timescale 1ns/1ns
module irq_routing_chk
   import irq_routing_pkg::*;
#(
   parameter int TIMEOUT_LIMIT = 20
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire apb_req_type apb_req,
   input wire apb_rsp_type apb_rsp,
   input wire logic power_fail,
   input wire logic dma_end_of_process,
   input wire logic [3:0] ring_indicator,
   input wire logic bus_flag_write,
   input wire logic bus_request,
   input wire logic bus_granted,
   input wire logic bus_cycle,
   input wire logic bus_ack,
   input wire logic nmi,
   input wire logic [BUS_LEVELS-1:0] bus_int_out,
   input wire glue_state_type glue_state
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic wr;
   logic ack_wr;
   logic pulse_clr;
   int stall_cnt;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign ack_wr = wr && apb_req.paddr == OFS_FLAG_ACK;
   assign pulse_clr = wr && apb_req.paddr == OFS_LATCH_CLR && apb_req.pwdata[ST_PULSE_LATCH];
   sequence flag_set_wr;
      wr && apb_req.paddr == OFS_FLAG_SET;
   endsequence
   // Raw stall count; margin of 8 covers the pin synchroniser
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !((bus_request && !bus_granted) || (bus_cycle && !bus_ack)))
         stall_cnt <= 0;
      else if (stall_cnt <= TIMEOUT_LIMIT + 8)
         stall_cnt <= stall_cnt + 1;
   end
   nmi_follows_a: assert property (power_fail [*6] |-> nmi)
      else $error("nmi missing after power fail");
   nmi_drops_a: assert property ((!power_fail) [*6] |-> !nmi)
      else $error("nmi stuck after power fail gone");
   flag_set_a: assert property (flag_set_wr |=> glue_state.flag_out)
      else $error("flag set write ignored");
   flag_hold_a: assert property (glue_state.flag_out && !ack_wr |=> glue_state.flag_out)
      else $error("bus flag dropped without acknowledge");
   bus_line_a: assert property (glue_state.flag_out [*2] |-> $onehot(bus_int_out))
      else $error("bus interrupt not one line");
   bus_idle_a: assert property ((!glue_state.flag_out) [*2] |-> bus_int_out == '0)
      else $error("bus interrupt without flag");
   pulse_catch_a: assert property ($rose(dma_end_of_process) |-> ##[1:8] glue_state.pulse_latch)
      else $error("end of process pulse lost");
   pulse_hold_a: assert property (glue_state.pulse_latch && !pulse_clr |=> glue_state.pulse_latch)
      else $error("pulse latch dropped");
   ring_catch_a: assert property ((ring_indicator & ~$past(ring_indicator)) != 4'h0 |-> ##[1:8] glue_state.ring_latch)
      else $error("ring event lost");
   flag_in_a: assert property ($rose(bus_flag_write) |-> ##[1:8] glue_state.flag_in)
      else $error("flag byte write lost");
   stall_timeout_a: assert property (stall_cnt == TIMEOUT_LIMIT + 8 |-> glue_state.timeout)
      else $error("bus stall without timeout");
   bus_error_a: assert property (apb_req.psel && apb_req.penable
      |-> apb_rsp.pslverr == (apb_req.paddr > OFS_TIMEOUT || apb_req.paddr[1:0] != 2'h0))
      else $error("unmapped access not refused");
endmodule

/* File: irq_routing_pkg.sv */
/*
   Shared constants and types for the board interrupt routing block.
   Assumes a 32-bit APB slave on clk_sys and word-aligned registers.
*/
package irq_routing_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LATCH_CLR = 8'h08;
   localparam logic [7:0] OFS_FLAG_SET = 8'h0C;
   localparam logic [7:0] OFS_FLAG_ACK = 8'h10;
   localparam logic [7:0] OFS_OR_SEL = 8'h14;
   localparam logic [7:0] OFS_NOR_SEL = 8'h18;
   localparam logic [7:0] OFS_MASTER_MASK = 8'h1C;
   localparam logic [7:0] OFS_SLAVE_MASK = 8'h20;
   localparam logic [7:0] OFS_PENDING = 8'h24;
   localparam logic [7:0] OFS_TIMEOUT = 8'h28;

   // Control field positions
   localparam int CTRL_BUS_LINE_LSB = 0;
   localparam int CTRL_BUS_LINE_W = 3;

   // Status/clear field positions
   localparam int ST_PULSE_LATCH = 0;
   localparam int ST_RING_LATCH = 1;
   localparam int ST_FLAG_IN = 2;
   localparam int ST_FLAG_OUT = 3;
   localparam int ST_TIMEOUT = 4;

   // Reset values
   localparam logic [2:0] RST_BUS_LINE = 3'h0;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [3:0] RST_OR_SEL = 4'h0;
   localparam logic [1:0] RST_NOR_SEL = 2'h0;

   // Level counts
   localparam int MASTER_LEVELS = 8;
   localparam int SLAVE_LEVELS = 5;
   localparam int BUS_LEVELS = 8;
   localparam int SERIAL_DEVICES = 4;
   localparam int CAUSES_PER_DEVICE = 8;
   localparam int CASCADE_INPUT = 7;

   // Bus acquisition / acknowledge timeout
   localparam int TIMEOUT_US = 10;
   localparam int CLK_MHZ = 100;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic pulse_latch;
      logic ring_latch;
      logic flag_in;
      logic flag_out;
      logic timeout;
   } glue_state_type;

endpackage

/* File: test_board_interrupt_routing.sv */
/*
   Self-checking bench for the routing block over APB.
   Assumes the bus host model and the checker are compiled alongside.
*/
`timescale 1ns/1ns
module test_board_interrupt_routing
   import irq_routing_pkg::*;
;
   localparam int TL = 20;
   localparam logic [12:0] tab [6] = '{13'h1808, 13'h0008, 13'h1020, 13'h0024, 13'h1010, 13'h0000};
   logic clk_sys, rst_n, stall, flag_go, snap, power_fail, dma_end_of_process, bus_request, bus_cycle;
   logic bus_granted, bus_ack, bus_flag_write, nmi, cpu_int;
   logic [31:0] serial_cause, got;
   logic [2:0] slave_timer, master_timer;
   logic [1:0] slave_dma;
   logic [7:0] bus_int_in, bus_int_out;
   logic [3:0] expansion_int, ring_indicator;
   logic [4:0] cpu_vector;
   logic [63:0] e;
   logic [63:0] q[$];
   apb_req_type apb_req;
   apb_rsp_type apb_rsp;
   glue_state_type glue_state;
   int mismatches, num_checks, cycles, i, b;
   board_interrupt_routing #(.TIMEOUT_LIMIT(TL)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .serial_cause(serial_cause), .slave_timer(slave_timer), .slave_dma(slave_dma),
      .master_timer(master_timer), .bus_int_in(bus_int_in), .expansion_int(expansion_int),
      .power_fail(power_fail), .dma_end_of_process(dma_end_of_process), .ring_indicator(ring_indicator),
      .bus_flag_write(bus_flag_write), .bus_request(bus_request), .bus_granted(bus_granted),
      .bus_cycle(bus_cycle), .bus_ack(bus_ack), .nmi(nmi), .cpu_int(cpu_int), .cpu_vector(cpu_vector),
      .bus_int_out(bus_int_out), .glue_state(glue_state));
   bus_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .flag_go(flag_go),
      .bus_request(bus_request), .bus_cycle(bus_cycle), .bus_granted(bus_granted), .bus_ack(bus_ack),
      .bus_flag_write(bus_flag_write));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   // Oldest note against read data, or against the pins when snap is up
   always @(posedge clk_sys)
   begin
      if ((apb_req.psel && apb_req.penable && !apb_req.pwrite) || snap)
      begin
         got = snap ? {17'h0, nmi, cpu_int, cpu_vector, bus_int_out} : apb_rsp.prdata;
         e = q.pop_front();
         num_checks++;
         if ((got & e[63:32]) !== e[31:0])
         begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e[31:0]);
         end
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      @(posedge clk_sys);
      // Only the bench timeout ends a stuck wait
      while (apb_rsp.pready !== 1'b1)
         @(posedge clk_sys);
      apb_req <= '0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      q.push_back({32'hFFFF_FFFF, x});
      xfer(1'b0, a, 32'h0);
   endtask
   task look(input logic [31:0] m, input logic [31:0] x);
      q.push_back({m, x});
      snap <= 1'b1;
      @(posedge clk_sys);
      snap <= 1'b0;
      @(posedge clk_sys);
   endtask
   initial
   begin
      {stall, flag_go, snap, power_fail, dma_end_of_process, bus_request, bus_cycle} = '0;
      {serial_cause, slave_timer, master_timer, slave_dma, bus_int_in, expansion_int, ring_indicator} = '0;
      apb_req = '0;
      rst_n = 1'b0;
      void'($urandom(55));
      tick(20);
      rst_n <= 1'b1;
      for (i = 0; i <= 44; i += 4)
         rd(i[7:0], 32'h0);
      wr(8'h8C, 32'hFFFF_FFFF);
      rd(OFS_STATUS, 32'h0);
      power_fail <= 1'b1;
      tick(8);
      look(32'h0000_4000, 32'h0000_4000);
      power_fail <= 1'b0;
      tick(8);
      look(32'h0000_4000, 32'h0);
      wr(OFS_MASTER_MASK, 32'h0000_00FF);
      for (i = 0; i < 7; i++)
      begin
         b = $urandom % 16;
         case (i)
            0: serial_cause[b] <= 1'b1;
            1: serial_cause[16 + b] <= 1'b1;
            5: bus_int_in[b % 8] <= 1'b1;
            6: expansion_int[b % 2] <= 1'b1;
            default: master_timer[i - 2] <= 1'b1;
         endcase
         tick(8);
         look(32'h0000_7F00, {18'h0, 1'b1, i[4:0], 8'h0});
         rd(OFS_PENDING, (i == 5 ? 32'h1 << (8 + b % 8) : 32'h0) | (32'h1 << i));
         {serial_cause, master_timer, bus_int_in, expansion_int} <= '0;
         tick(8);
      end
      master_timer <= 3'h7;
      tick(4);
      look(32'h0000_3F00, 32'h0000_2200);
      wr(OFS_MASTER_MASK, 32'h0000_00FB);
      tick(3);
      look(32'h0000_3F00, 32'h0000_2300);
      wr(OFS_MASTER_MASK, 32'h0000_0080);
      tick(3);
      look(32'h0000_2000, 32'h0);
      master_timer <= 3'h0;
      wr(OFS_SLAVE_MASK, 32'h0000_001F);
      for (i = 0; i < 5; i++)
      begin
         {slave_dma, slave_timer} <= 5'h1 << i;
         tick(4);
         look(32'h0000_7F00, {18'h0, 1'b1, 2'b10, i[2:0], 8'h0});
      end
      wr(OFS_SLAVE_MASK, 32'h0000_000F);
      tick(3);
      look(32'h0000_2000, 32'h0);
      {slave_dma, slave_timer} <= 5'h0;
      b = $urandom % 8;
      for (i = 0; i < 8; i++)
      begin
         wr(OFS_CTRL, 32'((i + b) % 8));
         wr(OFS_FLAG_SET, $urandom);
         tick(2);
         look(32'h0000_00FF, 32'h1 << ((i + b) % 8));
         rd(OFS_STATUS, 32'h8);
         wr(OFS_FLAG_ACK, $urandom);
         tick(2);
         look(32'h0000_00FF, 32'h0);
      end
      wr(OFS_MASTER_MASK, 32'h0000_0020);
      flag_go <= 1'b1;
      tick(1);
      flag_go <= 1'b0;
      tick(8);
      rd(OFS_STATUS, 32'h4);
      look(32'h0000_3F00, 32'h0000_2500);
      tick(10);
      rd(OFS_STATUS, 32'h4);
      wr(OFS_LATCH_CLR, 32'h4);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_OR_SEL, 32'h3);
      for (i = 0; i < 5; i++)
      begin
         if (i == 0)
            dma_end_of_process <= 1'b1;
         else
            ring_indicator[i - 1] <= 1'b1;
         tick(3);
         {dma_end_of_process, ring_indicator} <= 5'h0;
         tick(8);
         rd(OFS_STATUS, i == 0 ? 32'h1 : 32'h2);
         rd(OFS_PENDING, 32'h20);
         wr(OFS_LATCH_CLR, i == 0 ? 32'h2 : 32'h1);
         rd(OFS_STATUS, i == 0 ? 32'h1 : 32'h2);
         wr(OFS_LATCH_CLR, 32'h3);
         rd(OFS_STATUS, 32'h0);
      end
      for (i = 0; i < 6; i++)
      begin
         wr(OFS_OR_SEL, 32'(tab[i][11:8]));
         wr(OFS_NOR_SEL, 32'(tab[i][7:4]));
         expansion_int <= tab[i][3:0];
         tick(4);
         rd(OFS_PENDING, {26'h0, tab[i][12], 5'h0});
      end
      expansion_int <= 4'h0;
      wr(OFS_OR_SEL, 32'h4);
      for (i = 0; i < 4; i++)
      begin
         stall <= i[0];
         bus_cycle <= i[1];
         bus_request <= !i[1];
         tick(TL + 12);
         rd(OFS_STATUS, {27'h0, i[0], 4'h0});
         rd(OFS_TIMEOUT, i[0] ? 32'(TL) : 32'h0);
         rd(OFS_PENDING, {26'h0, i[0], 5'h0});
         {bus_request, bus_cycle, stall} <= 3'h0;
         tick(8);
         wr(OFS_LATCH_CLR, 32'h10);
      end
      finish_test();
   end
endmodule
bind board_interrupt_routing irq_routing_chk #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .power_fail(power_fail),
   .dma_end_of_process(dma_end_of_process), .ring_indicator(ring_indicator), .bus_flag_write(bus_flag_write),
   .bus_request(bus_request), .bus_granted(bus_granted), .bus_cycle(bus_cycle), .bus_ack(bus_ack), .nmi(nmi),
   .bus_int_out(bus_int_out), .glue_state(glue_state));
